// >>> uart_tx_rx_core.sv
// full-duplex uart core with register port, line pins and shift-clock pin
// assumes one 100 MHz clock; rxd and sync_clk_pin_in are asynchronous pins
//
// Overview of operation
// [R1] parity bit is low when data parity matches selected sense, else high
// [R2] receiver flags parity error when received parity bit disagrees
// [R3] parity disabled: no parity slot, a stop bit takes its place
// [R4] control bits 3:2 pick 8, 7, 6 or 5 data bits
// [R5] control bits 5:4 pick async, sync receive, or sync transmit
// [R6] enabled receiver splits each bit into 16 ticks; disabled it idles
// [R7] start edge accepted only if line still low at mid-bit
// [R8] bits sampled at bit centre, first bit is the lsb
// [R9] unused upper received data bits read as one
// [R10] one parity and one stop bit; flags updated, clean data loaded
// [R11] sync receive takes 8 bits on rising edges of external shift clock
// [R12] write to data register with transmitter on starts the frame, lsb first
// [R13] double-buffered transmitter; status bit 6 shows buffer free
// [R14] sync transmit sends 8 bits, drives shift clock, changes on falling edge
// [R15] receive-full sets on clean load, clears on reset or data read
// [R16] overrun keeps old character, drops new, clears on data read
// [R17] parity error only with parity on and async receiver
// [R18] framing error when first stop slot is low
// [R19] idle bit masks receive flags until ten high bits, then self-clears
// [R20] end-of-transmission masks tx empty until done; cleared by data write
// [R21] tx empty set by reset and transfer, cleared by data write
// [R22] tx done clears on reset and on transfer to shift register
// [R23] tx interrupt when empty and not end, or empty and done
// [R24] rx interrupt when full, overrun, parity or framing error is set
// [R25] async transmit line idles high and stop bits are high
`timescale 1ns/1ps
`include "uart_consts.svh"
`default_nettype none
module uart_tx_rx_core (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [2:0]   addr,
  input  wire uart_pkg::byte_t wdata,
  input  wire logic         wr,
  input  wire logic         rd,
  output logic [7:0]        rdata,
  input  wire logic         rxd,
  output logic              txd,
  input  wire logic         sync_clk_pin_in,
  output logic              sync_clk_pin_out,
  output logic              sync_clk_pin_oe,
  output logic              irq_n
);
  import uart_pkg::*;

  // ==========================================================
  // helpers
  function automatic logic [3:0] nbits(input logic [1:0] len);
    nbits = `FULL_BITS - {2'b00, len};
  endfunction : nbits

  // right-align a byte shifted in from the top and pad with ones
  function automatic byte_t align(input byte_t sh, input logic [3:0] n);
    byte_t ones;
    ones  = 8'hFF << n;
    align = (sh >> (`FULL_BITS - n)) | ones;
  endfunction : align

  // ==========================================================
  // registers and synchronisers
  byte_t       ctrl_q, irqen_q, rx_data_q, tx_buf_q;
  logic [15:0] baud_q, baud_cnt_q;
  logic [7:0]  stat_q;
  logic [1:0]  rx_ff_q, sck_ff_q;
  logic        rxs_prev_q, sck_prev_q;
  logic        tick, par_on, tx_sync, rx_sync, tx_load, tx_fin;
  logic        rx_done, rx_perr, rx_ferr;
  logic        tx_flag, rx_flag, tx_empty_vis;
  logic [3:0]  tx_n, rx_n;
  wire         rxs = rx_ff_q[1];
  wire         sck = sck_ff_q[1];

  assign par_on  = ctrl_q[`C_PAREN];
  assign tx_sync = ctrl_q[`C_FRMHI];                                      // [R5]
  assign rx_sync = (ctrl_q[`C_FRMHI:`C_FRMLO] == 2'b01);                   // [R5]
  assign tx_n    = tx_sync ? `SYNC_BITS : nbits(ctrl_q[`C_LENHI:`C_LENLO]); // [R4]
  assign rx_n    = nbits(ctrl_q[`C_LENHI:`C_LENLO]);                       // [R4]

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_ff_q    <= 2'b11;
      sck_ff_q   <= 2'b11;
      rxs_prev_q <= 1'b1;
      sck_prev_q <= 1'b1;
    end else begin
      rx_ff_q    <= {rx_ff_q[0], rxd};
      sck_ff_q   <= {sck_ff_q[0], sync_clk_pin_in};
      rxs_prev_q <= rxs;
      sck_prev_q <= sck;
    end
  end

  // ==========================================================
  // baud divider: one tick per sixteenth of a bit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      baud_cnt_q <= `BAUD_RST;
    end else if (baud_cnt_q == 16'h0000) begin
      baud_cnt_q <= baud_q;
    end else begin
      baud_cnt_q <= baud_cnt_q - 16'h0001;
    end
  end
  assign tick = (baud_cnt_q == 16'h0000);                                  // [R6]

  // ==========================================================
  // register writes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q   <= `CTRL_RST;
      irqen_q  <= 8'h00;
      baud_q   <= `BAUD_RST;
      tx_buf_q <= 8'h00;
    end else if (wr) begin
      if (addr == `A_CTRL) begin
        ctrl_q <= wdata;
      end else if (addr == `A_DATA) begin
        tx_buf_q <= wdata;
      end else if (addr == `A_IRQEN) begin
        irqen_q <= wdata & 8'hC0;
      end else if (addr == `A_BAUDLO) begin
        baud_q[7:0] <= wdata;
      end else if (addr == `A_BAUDHI) begin
        baud_q[15:8] <= wdata;
      end
    end
  end

  // ==========================================================
  // transmitter
  tx_state_t  tx_st_q;
  logic [3:0] tx_tick_q, tx_cnt_q;
  byte_t      tx_sh_q;
  logic       tx_par_q, txd_q, sck_out_q;
  wire        tx_bit_end = tick && (tx_tick_q == `TICK_LAST);

  assign tx_load = (tx_st_q == TX_IDLE) && ctrl_q[`C_TXON] && !stat_q[`S_TX_EMPTY]; // [R12]
  assign tx_fin  = tx_bit_end && ((tx_st_q == TX_STOP) ||
                   (tx_sync && tx_st_q == TX_DATA && tx_cnt_q == tx_n - 4'h1));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_st_q   <= TX_IDLE;
      tx_tick_q <= 4'h0;
      tx_cnt_q  <= 4'h0;
      tx_sh_q   <= 8'h00;
      tx_par_q  <= 1'b0;
      txd_q     <= 1'b1;
      sck_out_q <= 1'b1;
    end else if (tx_st_q == TX_IDLE) begin
      txd_q     <= tx_sync ? txd_q : 1'b1;                                  // [R25]
      sck_out_q <= 1'b1;
      if (tx_load) begin
        tx_tick_q <= 4'h0;
        tx_cnt_q  <= 4'h0;
        // parity over the data bits actually sent
        tx_par_q  <= ^(tx_buf_q & ~(8'hFF << tx_n)) ^ ~ctrl_q[`C_EVEN];   // [R1]
        if (tx_sync) begin
          tx_st_q   <= TX_DATA;                                           // [R14]
          txd_q     <= tx_buf_q[0];
          tx_sh_q   <= tx_buf_q >> 1;
          sck_out_q <= 1'b0;
        end else begin
          tx_st_q <= TX_START;
          txd_q   <= 1'b0;                                                // [R12]
          tx_sh_q <= tx_buf_q;
        end
      end
    end else if (tick) begin
      tx_tick_q <= tx_tick_q + 4'h1;
      if (tx_sync && tx_tick_q == `TICK_MID) begin
        sck_out_q <= 1'b1;                                                // [R14]
      end
      if (tx_bit_end) begin
        case (tx_st_q)
          TX_START: begin
            tx_st_q <= TX_DATA;
            txd_q   <= tx_sh_q[0];                                        // [R12]
            tx_sh_q <= tx_sh_q >> 1;
          end
          TX_DATA: begin
            tx_cnt_q <= tx_cnt_q + 4'h1;
            if (tx_cnt_q != tx_n - 4'h1) begin
              txd_q   <= tx_sh_q[0];
              tx_sh_q <= tx_sh_q >> 1;
              if (tx_sync) begin
                sck_out_q <= 1'b0;                                        // [R14]
              end
            end else if (tx_sync) begin
              tx_st_q <= TX_IDLE;                                         // [R14]
            end else if (par_on) begin
              tx_st_q <= TX_PAR;
              txd_q   <= tx_par_q;                                        // [R1]
            end else begin
              tx_st_q <= TX_STOP;                                         // [R3]
              txd_q   <= 1'b1;
            end
          end
          TX_PAR: begin
            tx_st_q <= TX_STOP;
            txd_q   <= 1'b1;                                              // [R25]
          end
          default: begin
            tx_st_q <= TX_IDLE;
          end
        endcase
      end
    end
  end

  assign txd              = txd_q;
  assign sync_clk_pin_out = sck_out_q;
  assign sync_clk_pin_oe  = tx_sync;                                      // [R14]

  // ==========================================================
  // receiver
  rx_state_t  rx_st_q;
  logic [3:0] rx_tick_q, rx_cnt_q;
  byte_t      rx_sh_q;
  logic       rx_pbit_q, rx_done_q, rx_perr_q, rx_ferr_q;
  logic [7:0] idle_cnt_q;
  wire        sck_rise = sck && !sck_prev_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_st_q   <= RX_IDLE;
      rx_tick_q <= 4'h0;
      rx_cnt_q  <= 4'h0;
      rx_sh_q   <= 8'h00;
      rx_pbit_q <= 1'b0;
      rx_done_q <= 1'b0;
      rx_perr_q <= 1'b0;
      rx_ferr_q <= 1'b0;
    end else begin
      rx_done_q <= 1'b0;
      if (!ctrl_q[`C_RXON]) begin
        rx_st_q  <= RX_IDLE;                                              // [R6]
        rx_cnt_q <= 4'h0;
      end else if (rx_sync) begin
        rx_st_q <= RX_IDLE;
        if (sck_rise) begin
          rx_sh_q   <= {rxs, rx_sh_q[7:1]};                               // [R11]
          rx_cnt_q  <= (rx_cnt_q == `SYNC_BITS - 4'h1) ? 4'h0 : rx_cnt_q + 4'h1;
          rx_done_q <= (rx_cnt_q == `SYNC_BITS - 4'h1);
          rx_perr_q <= 1'b0;
          rx_ferr_q <= 1'b0;
        end
      end else if (rx_st_q == RX_IDLE) begin
        rx_cnt_q <= 4'h0;
        if (!rxs && rxs_prev_q) begin
          rx_st_q   <= RX_START;
          rx_tick_q <= 4'h0;
        end
      end else if (tick) begin
        rx_tick_q <= rx_tick_q + 4'h1;
        if (rx_st_q == RX_START && rx_tick_q == `TICK_MID) begin
          rx_tick_q <= 4'h0;
          rx_st_q   <= rxs ? RX_IDLE : RX_DATA;                           // [R7]
        end else if (rx_st_q != RX_START && rx_tick_q == `TICK_LAST) begin
          case (rx_st_q)                                                  // [R8]
            RX_DATA: begin
              rx_sh_q  <= {rxs, rx_sh_q[7:1]};
              rx_cnt_q <= rx_cnt_q + 4'h1;
              if (rx_cnt_q == rx_n - 4'h1) begin
                rx_st_q <= par_on ? RX_PAR : RX_STOP;                     // [R3]
              end
            end
            RX_PAR: begin
              rx_pbit_q <= rxs;
              rx_st_q   <= RX_STOP;
            end
            default: begin
              rx_st_q   <= RX_IDLE;                                       // [R10]
              rx_done_q <= 1'b1;
              rx_ferr_q <= !rxs;                                          // [R18]
              rx_perr_q <= par_on && (rx_pbit_q !=                        // [R2]
                (^(align(rx_sh_q, rx_n) & ~(8'hFF << rx_n)) ^ ~ctrl_q[`C_EVEN]));
            end
          endcase
        end
      end
    end
  end

  assign rx_done = rx_done_q;
  assign rx_perr = rx_perr_q && !rx_sync;                                 // [R17]
  assign rx_ferr = rx_ferr_q && !rx_sync;

  // counts ticks of unbroken mark on the line for the idle bit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idle_cnt_q <= 8'h00;
    end else if (!rxs || !stat_q[`S_IDLE]) begin
      idle_cnt_q <= 8'h00;
    end else if (tick && idle_cnt_q != `IDLE_TICKS) begin
      idle_cnt_q <= idle_cnt_q + 8'h01;                                   // [R19]
    end
  end

  // ==========================================================
  // status flags; a hardware set wins over a same-cycle clear
  wire data_rd = rd && (addr == `A_DATA);
  wire data_wr = wr && (addr == `A_DATA);
  wire st_wr   = wr && (addr == `A_STAT);
  wire rx_live = rx_done && ctrl_q[`C_RXON] && !stat_q[`S_IDLE];          // [R19]
  wire rx_bad  = rx_perr || rx_ferr;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stat_q    <= 8'h00;
      stat_q[`S_TX_EMPTY] <= 1'b1;                                          // [R21]
      rx_data_q <= 8'hFF;
    end else begin
      if (data_rd) begin
        stat_q[`S_FRM:`S_FULL] <= 4'h0;                                   // [R15]
      end
      if (rx_live) begin
        if (rx_bad) begin
          if (rx_perr) stat_q[`S_PAR] <= 1'b1;                            // [R17]
          if (rx_ferr) stat_q[`S_FRM] <= 1'b1;                            // [R18]
        end else if (stat_q[`S_FULL] && !data_rd) begin
          stat_q[`S_OVR] <= 1'b1;                                         // [R16]
        end else begin
          stat_q[`S_FULL] <= 1'b1;                                        // [R15]
          rx_data_q <= rx_sync ? rx_sh_q : align(rx_sh_q, rx_n);          // [R9]
        end
      end
      if (st_wr && wdata[`S_IDLE]) begin
        stat_q[`S_IDLE] <= 1'b1;
      end else if (idle_cnt_q == `IDLE_TICKS) begin
        stat_q[`S_IDLE] <= 1'b0;                                          // [R19]
      end
      if (st_wr && wdata[`S_END_TX]) begin
        stat_q[`S_END_TX] <= 1'b1;
      end else if (data_wr) begin
        stat_q[`S_END_TX] <= 1'b0;                                          // [R20]
      end
      if (tx_load) begin
        stat_q[`S_TX_EMPTY] <= 1'b1;                                        // [R21]
        stat_q[`S_TX_DONE]  <= 1'b0;                                        // [R22]
      end else begin
        if (data_wr) stat_q[`S_TX_EMPTY] <= 1'b0;                           // [R21]
        if (tx_fin)  stat_q[`S_TX_DONE]  <= 1'b1;
      end
    end
  end

  assign tx_empty_vis = stat_q[`S_TX_EMPTY] && (!stat_q[`S_END_TX] || stat_q[`S_TX_DONE]); // [R20]
  assign tx_flag = irqen_q[`I_TX] && tx_empty_vis;                        // [R23]
  assign rx_flag = irqen_q[`I_RX] && (|stat_q[`S_FRM:`S_FULL]);           // [R24]

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_n <= 1'b1;
    end else begin
      irq_n <= !(tx_flag || rx_flag);                                     // [R23]
    end
  end

  // ==========================================================
  // read port: data stand one cycle after the strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (rd) begin
      if (addr == `A_CTRL) begin
        rdata <= ctrl_q;
      end else if (addr == `A_STAT) begin
        rdata <= {stat_q[7], tx_empty_vis, stat_q[5:0]};                  // [R13]
      end else if (addr == `A_DATA) begin
        rdata <= rx_data_q;
      end else if (addr == `A_IRQEN) begin
        rdata <= irqen_q;
      end else if (addr == `A_IRQFLG) begin
        rdata <= {tx_flag, rx_flag, 6'h00};
      end else if (addr == `A_BAUDLO) begin
        rdata <= baud_q[7:0];
      end else if (addr == `A_BAUDHI) begin
        rdata <= baud_q[15:8];
      end else begin
        rdata <= 8'h00;
      end
    end else begin
      rdata <= 8'h00;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_start_seen;
    (rx_st_q == RX_START) && tick && (rx_tick_q == `TICK_MID);
  endsequence

  AST_START_VALID: assert property (s_start_seen ##0 rxs |=> rx_st_q == RX_IDLE) // [R7]
    else $error("start accepted on a high line");
  AST_RX_OFF: assert property (!ctrl_q[`C_RXON] |=> rx_st_q == RX_IDLE)          // [R6]
    else $error("receiver active while disabled");
  AST_FULL_CLEAN: assert property (rx_live && !rx_bad && !stat_q[`S_FULL]
    |=> stat_q[`S_FULL]) else $error("clean character did not set full");      // [R15]
  AST_OVR_KEEP: assert property (rx_live && !rx_bad && stat_q[`S_FULL] && !data_rd
    |=> stat_q[`S_OVR] && $stable(rx_data_q)) else $error("overrun lost old data"); // [R16]
  AST_RD_CLEAR: assert property (data_rd && !rx_live
    |=> stat_q[`S_FRM:`S_FULL] == 4'h0) else $error("data read did not clear flags"); // [R15]
  AST_TX_EMPTY_WR: assert property (data_wr && !tx_load |=> !stat_q[`S_TX_EMPTY]
    && !stat_q[`S_END_TX]) else $error("data write did not clear empty");       // [R21]
  AST_LOAD: assert property (tx_load |=> stat_q[`S_TX_EMPTY] && !stat_q[`S_TX_DONE]
    && tx_st_q != TX_IDLE) else $error("transfer to shift register wrong");   // [R22]
  AST_TX_IDLE_HIGH: assert property (tx_st_q == TX_IDLE && !tx_sync && !tx_load
    |=> txd) else $error("async line not high when idle");                    // [R25]
  AST_START_LOW: assert property (tx_load && !tx_sync |=> !txd [*2])
    else $error("start bit not low");                                         // [R12]
  AST_IRQ: assert property ((tx_flag || rx_flag) |=> !irq_n)
    else $error("interrupt not raised");                                      // [R24]
endmodule : uart_tx_rx_core
`default_nettype wire

// >>> uart_consts.svh
// constants for the uart core: register map, field positions, reset values
// assumes inclusion by bare name from the core and the testbench
`ifndef UART_CONSTS_SVH
`define UART_CONSTS_SVH
`define A_CTRL      3'h0
`define A_STAT      3'h1
`define A_DATA      3'h2
`define A_IRQEN     3'h3
`define A_IRQFLG    3'h4
`define A_BAUDLO    3'h5
`define A_BAUDHI    3'h6
`define C_EVEN      0
`define C_PAREN     1
`define C_LENLO     2
`define C_LENHI     3
`define C_FRMLO     4
`define C_FRMHI     5
`define C_RXON      6
`define C_TXON      7
`define S_FULL      0
`define S_OVR       1
`define S_PAR       2
`define S_FRM       3
`define S_IDLE      4
`define S_END_TX      5
`define S_TX_EMPTY    6
`define S_TX_DONE     7
`define I_TX        7
`define I_RX        6
`define CTRL_RST    8'h00
`define BAUD_RST    16'h0001
`define TICK_MID    4'h7
`define TICK_LAST   4'hF
`define SYNC_BITS   4'h8
`define FULL_BITS   4'h8
`define IDLE_TICKS  8'hA0
`endif

// >>> uart_pkg.sv
// types shared by the uart core
// assumes uart_consts.svh is on the include path
package uart_pkg;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_t;
  typedef logic [7:0] byte_t;
endpackage : uart_pkg

// >>> serial_peer.sv
// remote serial party: drives the receive line and captures the transmit line
// assumes the baud divider is 0, so one bit lasts 16 clocks
`timescale 1ns/1ps
`default_nettype none
module serial_peer
  import uart_pkg::*;
(
  input  wire logic clk,
  input  wire logic txd,
  input  wire logic sclk,
  output logic      rxd,
  output logic      sclk_ext
);
  localparam int BIT = 16;
  logic [9:0] frames[$];
  byte_t      sync_sr;
  logic [9:0] fr;
  initial begin
    rxd      = 1'b1;
    sclk_ext = 1'b1;
  end
  // ==========================================
  // line driving
  task automatic bit_out(input logic v);
    @(posedge clk) rxd <= v;
    repeat (BIT - 1) @(posedge clk);
  endtask : bit_out
  // start, n data bits lsb first, optional parity, one stop
  task automatic send(input byte_t d, input int n, input logic pe, input logic pv,
                      input logic stop);
    bit_out(1'b0);
    for (int i = 0; i < n; i++) begin
      bit_out(d[i]);
    end
    if (pe) begin
      bit_out(pv);
    end
    bit_out(stop);
    @(posedge clk) rxd <= 1'b1;
  endtask : send
  // low pulse shorter than half a bit, must not start a character
  task automatic pulse(input int len);
    @(posedge clk) rxd <= 1'b0;
    repeat (len) @(posedge clk);
    rxd <= 1'b1;
  endtask : pulse
  // far side supplies the shift clock, data set half a period before each rise
  task automatic sync_send(input byte_t d);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk) begin
        rxd      <= d[i];
        sclk_ext <= 1'b0;
      end
      repeat (BIT / 2) @(posedge clk);
      sclk_ext <= 1'b1;
      repeat (BIT / 2 - 1) @(posedge clk);
    end
    @(posedge clk) rxd <= 1'b1;
  endtask : sync_send
  // ==========================================
  // line capture: ten slots after start, sampled mid-bit
  initial begin : catch_tx
    forever begin
      @(negedge txd);
      repeat (BIT / 2) @(posedge clk);
      if (txd === 1'b0) begin
        for (int i = 0; i < 10; i++) begin
          repeat (BIT) @(posedge clk);
          fr[i] = txd;
        end
        frames.push_back(fr);
      end
    end
  end
  // sync receive side: data is taken on the rising shift clock edge
  always @(posedge sclk) begin
    sync_sr <= {txd, sync_sr[7:1]};
  end
endmodule : serial_peer
`default_nettype wire

// >>> test_uart_tx_rx_core.sv
// self-checking bench for the uart core, register port plus serial peer
// assumes uart_consts.svh on the include path and a 100 MHz clock
`timescale 1ns/1ps
`include "uart_consts.svh"
`default_nettype none
module test_uart_tx_rx_core;
  import uart_pkg::*;
  logic       clk, rst, wr, rd, rxd, txd, sclk_out, sclk_oe, sclk_ext, irq_n;
  logic [2:0] addr;
  byte_t      wdata;
  logic [7:0] rdata;
  int         n_fail, samples_checked;
  typedef struct packed {byte_t ctrl; byte_t d; byte_t exp;} row_t;
  // control, sent data, expected received data
  row_t rows [4] = '{'{8'hC0, 8'h3C, 8'h3C}, '{8'hC4, 8'h5A, 8'hDA},
                     '{8'hCB, 8'h2D, 8'hED}, '{8'hCE, 8'h13, 8'hF3}};
  // ==========================================
  // design and peer
  uart_tx_rx_core uart_tx_rx_core_inst (.clk(clk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .rxd(rxd), .txd(txd),
    .sync_clk_pin_in(sclk_ext), .sync_clk_pin_out(sclk_out),
    .sync_clk_pin_oe(sclk_oe), .irq_n(irq_n));
  serial_peer serial_peer_inst (.clk(clk), .txd(txd), .sclk(sclk_out), .rxd(rxd),
    .sclk_ext(sclk_ext));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ==========================================
  // tasks
  task automatic tally_and_finish();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    #1;
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [2:0] a, input byte_t d);
    @(posedge clk) begin
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
    end
    @(posedge clk) wr <= 1'b0;
    // step off the edge so that callers read settled outputs
    #1;
  endtask : wr_reg
  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [2:0] a, input byte_t exp);
    @(posedge clk) begin
      addr <= a;
      rd   <= 1'b1;
    end
    @(posedge clk) rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask : rd_chk
  // flip turns the parity bit round on purpose
  task automatic rx_frame(input byte_t c, input byte_t d, input logic flip,
                          input logic stop);
    serial_peer_inst.send(d, 8 - c[3:2], c[1], ^d ^ ~c[0] ^ flip, stop);
    repeat (24) @(posedge clk);
    #1;
  endtask : rx_frame
  task automatic wait_frames(input int n);
    int k;
    k = 0;
    while (serial_peer_inst.frames.size() < n && k < 1000) begin
      @(posedge clk);
      k++;
    end
    if (k == 1000) begin
      n_fail++;
      tally_and_finish();
    end
  endtask : wait_frames
  // ==========================================
  // main sequence
  initial begin
    rst = 1'b1;
    addr = 3'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    n_fail = 0;
    samples_checked = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_chk(`A_STAT, 8'h40);
    rd_chk(`A_DATA, 8'hFF);
    rd_chk(3'h7, 8'h00);
    wr_reg(`A_BAUDLO, 8'h00);
    wr_reg(`A_BAUDHI, 8'h00);
    foreach (rows[i]) begin
      wr_reg(`A_CTRL, rows[i].ctrl);
      rx_frame(rows[i].ctrl, rows[i].d, 1'b0, 1'b1);
      rd_chk(`A_STAT, 8'h41);
      rd_chk(`A_DATA, rows[i].exp);
      rd_chk(`A_STAT, 8'h40);
    end
    // errored characters flag only and leave the old data in place
    wr_reg(`A_CTRL, 8'hCB);
    rx_frame(8'hCB, 8'h2D, 1'b1, 1'b1);
    rd_chk(`A_STAT, 8'h44);
    rd_chk(`A_DATA, 8'hF3);
    wr_reg(`A_CTRL, 8'hC0);
    rx_frame(8'hC0, 8'h55, 1'b0, 1'b0);
    rd_chk(`A_STAT, 8'h48);
    rd_chk(`A_DATA, 8'hF3);
    rx_frame(8'hC0, 8'h11, 1'b0, 1'b1);
    rx_frame(8'hC0, 8'h22, 1'b0, 1'b1);
    rd_chk(`A_STAT, 8'h43);
    rd_chk(`A_DATA, 8'h11);
    rd_chk(`A_STAT, 8'h40);
    serial_peer_inst.pulse(4);
    repeat (200) @(posedge clk);
    rd_chk(`A_STAT, 8'h40);
    // idle bit: the next character is ignored, then ten marks clear the bit
    wr_reg(`A_STAT, 8'h10);
    rx_frame(8'hC0, 8'h3C, 1'b0, 1'b1);
    rd_chk(`A_STAT, 8'h50);
    repeat (160) @(posedge clk);
    rd_chk(`A_STAT, 8'h40);
    rd_chk(`A_DATA, 8'h11);
    wr_reg(`A_IRQEN, 8'h40);
    rx_frame(8'hC0, 8'h77, 1'b0, 1'b1);
    chk(irq_n, 1'b0);
    rd_chk(`A_DATA, 8'h77);
    repeat (3) @(posedge clk);
    chk(irq_n, 1'b1);
    wr_reg(`A_IRQEN, 8'h80);
    repeat (3) @(posedge clk);
    chk(irq_n, 1'b0);
    wr_reg(`A_IRQEN, 8'h00);
    // receiver off, transmitter with even parity
    wr_reg(`A_CTRL, 8'h83);
    rx_frame(8'h83, 8'h66, 1'b0, 1'b1);
    rd_chk(`A_STAT, 8'h40);
    wr_reg(`A_DATA, 8'hA5);
    repeat (4) @(posedge clk);
    rd_chk(`A_STAT, 8'h40);
    wr_reg(`A_STAT, 8'h20);
    rd_chk(`A_STAT, 8'h20);
    wr_reg(`A_DATA, 8'hA7);
    rd_chk(`A_STAT, 8'h00);
    wait_frames(2);
    chk(serial_peer_inst.frames[0], 10'h2A5);
    chk(serial_peer_inst.frames[1], 10'h3A7);
    repeat (20) @(posedge clk);
    rd_chk(`A_STAT, 8'hC0);
    // synchronous receive on the far side's shift clock, then synchronous transmit on the core's own
    wr_reg(`A_CTRL, 8'h50);
    serial_peer_inst.sync_send(8'hC3);
    repeat (8) @(posedge clk);
    rd_chk(`A_STAT, 8'hC1);
    rd_chk(`A_DATA, 8'hC3);
    wr_reg(`A_CTRL, 8'hA0);
    chk(sclk_oe, 1'b1);
    wr_reg(`A_DATA, 8'h96);
    repeat (164) @(posedge clk);
    chk(serial_peer_inst.sync_sr, 8'h96);
    // reset in mid-run returns the flags and control to their reset values
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_chk(`A_STAT, 8'h40);
    rd_chk(`A_CTRL, 8'h00);
    tally_and_finish();
  end
endmodule : test_uart_tx_rx_core
`default_nettype wire
